// ### hdl/spi_nvm_pkg.sv
// Constants, field layouts and types shared by the SPI command and NVM controller
package spi_nvm_pkg;

  localparam int unsigned SYS_CLK_HZ        = 20_000_000;
  localparam int unsigned NVM_WORD_TIME_NS  = 1000;
  localparam int unsigned NVM_WORD_CYCLES   =
    (NVM_WORD_TIME_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;

  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned ADDR_W     = 5;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned NVM_WORDS  = 26;

  localparam logic [3:0]        LAST_BIT     = 4'hf;
  localparam logic [ADDR_W-1:0] ERR_ADDR     = 5'h1a;
  localparam logic [ADDR_W-1:0] STAT_ADDR    = 5'h1b;
  localparam logic [DATA_W-1:0] ERR_MASK     = 8'h0e;
  localparam int unsigned       ERR_LSB      = 1;
  localparam int unsigned       STAT_LSB     = 6;
  localparam logic [15:0]       REPLY_RESET  = 16'h0000;
  localparam logic [DATA_W-1:0] REG_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] FACTORY_R04  = 8'h6e;
  localparam logic [DATA_W-1:0] FACTORY_R06  = 8'h1d;
  localparam logic [DATA_W-1:0] FACTORY_R11  = 8'hc0;
  localparam logic [DATA_W-1:0] FACTORY_R14  = 8'h90;

  typedef enum logic [2:0] {
    CMD_READ_ANGLE = 3'b000,
    CMD_CLEAR_ERR  = 3'b001,
    CMD_READ_REG   = 3'b010,
    CMD_WRITE_REG  = 3'b100,
    CMD_RESTORE    = 3'b101,
    CMD_STORE_ALL  = 3'b110,
    CMD_STORE_ONE  = 3'b111
  } cmd_t;

  typedef struct packed {
    cmd_t              cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] value;
  } frame_t;

  typedef enum logic [1:0] {
    MEM_IDLE      = 2'b00,
    MEM_RESTORE   = 2'b01,
    MEM_STORE_ONE = 2'b10,
    MEM_STORE_ALL = 2'b11
  } mem_state_t;

  function automatic logic [DATA_W-1:0] factory_value(input int unsigned idx);
    case (idx)
      4:       factory_value = FACTORY_R04;
      6:       factory_value = FACTORY_R06;
      11:      factory_value = FACTORY_R11;
      14:      factory_value = FACTORY_R14;
      default: factory_value = REG_RESET;
    endcase
  endfunction : factory_value

endpackage : spi_nvm_pkg

// ### hdl/spi_cmd_nvm_control.sv
// SPI command interpreter with configuration registers and NVM store/restore control
//
// Contract
// - After reset, all configuration registers load from NVM without any command.
// - Command 111 stores the addressed register into NVM; reply is angle.
// - Command 110 stores every register into NVM; reply is angle.
// - Command 101 reloads every register from NVM; reply is angle.
// - Command 001 clears the error flags in register 26; reply is angle.
// - Store and restore commands arriving while memory is busy are dropped.
// - Busy output is high while memory works, low when ready.
// - 000 reads angle; 010/100 read/write register, reply angle high byte plus value.
`timescale 1ns/1ps

module spi_cmd_nvm_control #(
  parameter int unsigned WORDS      = spi_nvm_pkg::NVM_WORDS,
  parameter int unsigned WORD_WAIT  = spi_nvm_pkg::NVM_WORD_CYCLES
) (
  input  wire logic                                    sys_clk,
  input  wire logic                                    rst,
  input  wire logic                                    sclk,
  input  wire logic                                    cs_n,
  input  wire logic                                    mosi,
  output logic                                         miso,
  output logic                                         miso_oe_n,
  input  wire logic [15:0]                             angle,
  input  wire logic [2:0]                              error_event,
  input  wire logic [1:0]                              mag_flags,
  output logic                                         memory_busy_pin,
  output logic [WORDS*spi_nvm_pkg::DATA_W-1:0]         config_bits
);
  import spi_nvm_pkg::*;

  localparam logic [ADDR_W-1:0] LAST_WORD = ADDR_W'(WORDS - 1);
  localparam logic [7:0]        WAIT_LAST = 8'(WORD_WAIT - 1);

  // Link side, clocked by the master's serial clock
  logic [3:0]              bit_cnt;
  logic [FRAME_BITS-1:0]   rx_shift;
  logic [FRAME_BITS-1:0]   rx_hold;
  logic                    rx_toggle;
  logic [FRAME_BITS-1:0]   tx_shift;
  logic                    first_bit;

  // System side
  logic                    sync_a;
  logic                    sync_b;
  logic                    sync_c;
  logic                    frame_ev;
  frame_t                  frame;
  frame_t                  last_frame;
  logic                    reply_pend;
  logic [FRAME_BITS-1:0]   reply;
  logic [DATA_W-1:0]       regs [WORDS];
  // Non-volatile array: factory contents at power-up, never cleared by reset
  logic [DATA_W-1:0]       nvm  [WORDS] = '{4: FACTORY_R04, 6: FACTORY_R06, 11: FACTORY_R11,
                                            14: FACTORY_R14, default: REG_RESET};
  logic [DATA_W-1:0]       err_flags;
  mem_state_t              mem_state;
  logic [ADDR_W-1:0]       word_idx;
  logic [7:0]              wait_cnt;
  logic                    word_done;
  logic                    mem_cmd;
  logic                    accept_mem;
  logic                    clear_err;

  // Bit counter restarts whenever chip select is released
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge sclk) begin
    rx_shift <= {rx_shift[FRAME_BITS-2:0], mosi};
  end

  // Completed frame is held stable until the next frame completes
  always_ff @(posedge sclk) begin
    if (bit_cnt == LAST_BIT) begin
      rx_hold <= {rx_shift[FRAME_BITS-2:0], mosi};
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      rx_toggle <= 1'b0;
    end else if (bit_cnt == LAST_BIT) begin
      rx_toggle <= ~rx_toggle;
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      first_bit <= 1'b1;
    end else begin
      first_bit <= 1'b0;
    end
  end

  // Reply word is rewritten only in response to a finished frame, so it is static here
  always_ff @(negedge sclk) begin
    if (first_bit) begin
      tx_shift <= {reply[FRAME_BITS-2:0], 1'b0};
    end else begin
      tx_shift <= {tx_shift[FRAME_BITS-2:0], 1'b0};
    end
  end

  always_comb begin
    if (cs_n) begin
      miso = 1'b0;
    end else if (first_bit) begin
      miso = reply[FRAME_BITS-1];
    end else begin
      miso = tx_shift[FRAME_BITS-1];
    end
  end

  assign miso_oe_n = cs_n;

  // Frame event crosses as a toggle through two flip-flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= rx_toggle;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign frame_ev = sync_b ^ sync_c;
  assign frame    = frame_t'(rx_hold);

  always_comb begin
    case (frame.cmd)
      CMD_STORE_ONE,
      CMD_STORE_ALL,
      CMD_RESTORE: mem_cmd = 1'b1;
      default:     mem_cmd = 1'b0;
    endcase
  end

  assign accept_mem = frame_ev && mem_cmd && (mem_state == MEM_IDLE);
  assign clear_err  = frame_ev && (frame.cmd == CMD_CLEAR_ERR);
  assign word_done  = (mem_state != MEM_IDLE) && (wait_cnt == WAIT_LAST);

  function automatic logic [DATA_W-1:0] read_reg(input logic [ADDR_W-1:0] a);
    if (a < ADDR_W'(WORDS)) begin
      read_reg = regs[a];
    end else if (a == ERR_ADDR) begin
      read_reg = err_flags;
    end else if (a == STAT_ADDR) begin
      read_reg = {mag_flags, 6'h00};
    end else begin
      read_reg = REG_RESET;
    end
  endfunction : read_reg

  // Memory sequencer; reset starts an automatic restore of every word
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_state <= MEM_RESTORE;
      word_idx  <= '0;
      wait_cnt  <= 8'h00;
    end else if (accept_mem) begin
      wait_cnt <= 8'h00;
      case (frame.cmd)
        CMD_STORE_ONE: begin
          mem_state <= MEM_STORE_ONE;
          word_idx  <= frame.addr;
        end
        CMD_STORE_ALL: begin
          mem_state <= MEM_STORE_ALL;
          word_idx  <= '0;
        end
        default: begin
          mem_state <= MEM_RESTORE;
          word_idx  <= '0;
        end
      endcase
    end else if (mem_state != MEM_IDLE) begin
      if (!word_done) begin
        wait_cnt <= wait_cnt + 8'h01;
      end else begin
        wait_cnt <= 8'h00;
        if (mem_state == MEM_STORE_ONE || word_idx == LAST_WORD) begin
          mem_state <= MEM_IDLE;
        end else begin
          word_idx <= word_idx + ADDR_W'(1);
        end
      end
    end
  end

  assign memory_busy_pin = (mem_state != MEM_IDLE);

  always_ff @(posedge sys_clk) begin
    if (word_done && word_idx < ADDR_W'(WORDS)) begin
      if (mem_state == MEM_STORE_ONE || mem_state == MEM_STORE_ALL) begin
        nvm[word_idx] <= regs[word_idx];
      end
    end
  end

  // Volatile registers: restore has priority over a same-cycle write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < WORDS; i++) begin
        regs[i] <= REG_RESET;
      end
    end else if (word_done && mem_state == MEM_RESTORE) begin
      regs[word_idx] <= nvm[word_idx];
    end else if (frame_ev && frame.cmd == CMD_WRITE_REG && frame.addr < ADDR_W'(WORDS)) begin
      regs[frame.addr] <= frame.value;
    end
  end

  // Error flags: a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      err_flags <= REG_RESET;
    end else if (clear_err) begin
      err_flags <= {4'h0, error_event, 1'b0} & ERR_MASK;
    end else begin
      err_flags <= (err_flags | {4'h0, error_event, 1'b0}) & ERR_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reply_pend <= 1'b0;
      last_frame <= '0;
    end else begin
      reply_pend <= frame_ev;
      if (frame_ev) begin
        last_frame <= frame;
      end
    end
  end

  // Reply for the next frame, built one cycle after a frame so a write shows its new value
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reply <= REPLY_RESET;
    end else if (reply_pend) begin
      case (last_frame.cmd)
        CMD_READ_REG,
        CMD_WRITE_REG: reply <= {angle[15:8], read_reg(last_frame.addr)};
        default:       reply <= angle;
      endcase
    end
  end

  generate
    for (genvar g = 0; g < WORDS; g++) begin : g_cfg
      assign config_bits[g*DATA_W +: DATA_W] = regs[g];
    end
  endgenerate

endmodule : spi_cmd_nvm_control

// ### testbench/spi_master_model.sv
// Behavioural SPI master that sends 16-bit mode 0 frames
`timescale 1ns/1ps
module spi_master_model #(
  parameter int HALF = 3
) (
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_n = 1'b0;
    for (int k = 15; k >= 0; k--) begin
      mosi = tx[k];
      #HALF;
      rx[k] = miso;
      sclk  = 1'b1;
      #HALF;
      sclk  = 1'b0;
    end
    #HALF;
    cs_n = 1'b1;
    // Released line shows the inverse, never a stale bit
    mosi = ~mosi;
    // Gap so the reply for the next frame has settled
    #300;
  endtask : xfer
endmodule : spi_master_model

// ### testbench/spi_cmd_nvm_control_assertions.sv
// Port-level checks on the SPI command and NVM controller
`timescale 1ns/1ps
module spi_cmd_nvm_control_assertions #(
  parameter int unsigned WORDS     = spi_nvm_pkg::NVM_WORDS,
  parameter int unsigned WORD_WAIT = spi_nvm_pkg::NVM_WORD_CYCLES
) (
  input wire logic                                sys_clk,
  input wire logic                                rst,
  input wire logic                                cs_n,
  input wire logic                                miso,
  input wire logic                                miso_oe_n,
  input wire logic                                memory_busy_pin,
  input wire logic [WORDS*spi_nvm_pkg::DATA_W-1:0] config_bits
);
  import spi_nvm_pkg::*;
  int unsigned busy_run;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  always_ff @(posedge sys_clk) begin
    if (rst || !memory_busy_pin)
      busy_run <= 0;
    else
      busy_run <= busy_run + 1;
  end

  sequence quiet_link;
    cs_n [*8];
  endsequence

  a_busy_after_release: assert property ($fell(rst) |-> memory_busy_pin [*8])
    else $error("busy not held by restore after reset");
  a_busy_run_len: assert property ($fell(memory_busy_pin) |-> busy_run == WORD_WAIT ||
    (busy_run >= WORDS*WORD_WAIT-1 && busy_run <= WORDS*WORD_WAIT+1))
    else $error("busy length wrong");
  a_busy_run_max: assert property (busy_run <= WORDS*WORD_WAIT+1)
    else $error("busy stuck high");
  a_busy_rise_hold: assert property ($rose(memory_busy_pin) |-> memory_busy_pin [*2])
    else $error("busy dropped early");
  a_busy_needs_frame: assert property (quiet_link ##0 !memory_busy_pin |=> !memory_busy_pin)
    else $error("busy rose without a frame");
  a_config_quiet: assert property (quiet_link ##0 (!memory_busy_pin && !$past(memory_busy_pin))
    |-> $stable(config_bits))
    else $error("registers changed with no command");
  a_oe_follows_cs: assert property (miso_oe_n == cs_n)
    else $error("output enable differs from select");
  a_miso_idle_low: assert property (cs_n |-> !miso)
    else $error("miso not low while deselected");
endmodule : spi_cmd_nvm_control_assertions

bind spi_cmd_nvm_control spi_cmd_nvm_control_assertions #(.WORDS(WORDS), .WORD_WAIT(WORD_WAIT))
  chk (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .miso(miso), .miso_oe_n(miso_oe_n),
       .memory_busy_pin(memory_busy_pin), .config_bits(config_bits));

// ### testbench/spi_cmd_nvm_control_tb.sv
// Self-checking bench for the SPI command and NVM controller
`timescale 1ns/1ps
module spi_cmd_nvm_control_tb;
  import spi_nvm_pkg::*;
  localparam logic [15:0] ANG = 16'hc35a;
  localparam logic [7:0]  HI  = 8'hc3;
  typedef struct packed { frame_t tx; logic [15:0] exp; } row_t;
  logic                        sys_clk, rst, sclk, cs_n, mosi, miso, miso_oe_n, memory_busy_pin;
  logic [15:0]                 angle, rx;
  logic [2:0]                  error_event;
  logic [1:0]                  mag_flags;
  logic [NVM_WORDS*DATA_W-1:0] config_bits;
  int                          bad_count, n_compared, cycles;
  row_t                        rows [10];

  spi_cmd_nvm_control #(.WORD_WAIT(2)) dut (.sys_clk(sys_clk), .rst(rst), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n), .angle(angle),
    .error_event(error_event), .mag_flags(mag_flags), .memory_busy_pin(memory_busy_pin),
    .config_bits(config_bits));
  spi_master_model master (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  always #25 sys_clk = ~sys_clk;

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      $display("ERROR at %0t: run hung", $time);
      conclude();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wait_idle();
    int n;
    n = 0;
    while (memory_busy_pin !== 1'b0 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    #1;
    check({15'h0000, memory_busy_pin}, 16'h0000);
  endtask : wait_idle

  task automatic send(input frame_t f);
    @(posedge sys_clk);
    #1;
    master.xfer(f, rx);
  endtask : send

  initial begin
    sys_clk     = 1'b0;
    rst         = 1'b1;
    angle       = ANG;
    error_event = 3'b000;
    mag_flags   = 2'b10;
    rows = '{'{'{CMD_READ_ANGLE, 5'h00, 8'h00}, ANG}, '{'{CMD_WRITE_REG, 5'h05, 8'ha5}, {HI, 8'ha5}},
      '{'{CMD_READ_REG, 5'h05, 8'h00}, {HI, 8'ha5}}, '{'{CMD_READ_REG, 5'h04, 8'h00}, {HI, FACTORY_R04}},
      '{'{CMD_READ_REG, 5'h1b, 8'h00}, {HI, 8'h80}}, '{'{CMD_READ_REG, 5'h1a, 8'h00}, {HI, 8'h0a}},
      '{'{CMD_CLEAR_ERR, 5'h00, 8'h00}, ANG}, '{'{CMD_READ_REG, 5'h1a, 8'h00}, {HI, 8'h00}},
      '{'{CMD_STORE_ONE, 5'h05, 8'h00}, ANG}, '{'{CMD_READ_ANGLE, 5'h00, 8'h00}, ANG}};
    repeat (20) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    wait_idle();
    check({8'h00, config_bits[39:32]}, {8'h00, FACTORY_R04});
    check({8'h00, config_bits[55:48]}, {8'h00, FACTORY_R06});
    check({8'h00, config_bits[95:88]}, {8'h00, FACTORY_R11});
    check({8'h00, config_bits[119:112]}, {8'h00, FACTORY_R14});
    error_event = 3'b101;
    @(posedge sys_clk);
    #1;
    error_event = 3'b000;
    for (int i = 0; i < 10; i++) begin
      send(rows[i].tx);
      if (i > 0)
        check(rx, rows[i-1].exp);
    end
    check({8'h00, config_bits[47:40]}, 16'h00a5);
    wait_idle();
    send('{CMD_WRITE_REG, 5'h00, 8'h3c});
    check(rx, rows[9].exp);
    send('{CMD_STORE_ALL, 5'h00, 8'h00});
    check(rx, {HI, 8'h3c});
    check({15'h0000, memory_busy_pin}, 16'h0001);
    send('{CMD_WRITE_REG, 5'h00, 8'h77});
    check(rx, ANG);
    send('{CMD_STORE_ONE, 5'h00, 8'h00});
    wait_idle();
    send('{CMD_RESTORE, 5'h00, 8'h00});
    check({15'h0000, memory_busy_pin}, 16'h0001);
    wait_idle();
    check({8'h00, config_bits[7:0]}, 16'h003c);
    // Store-one must save only its own word; a later reset reloads from memory
    send('{CMD_WRITE_REG, 5'h05, 8'h11});
    send('{CMD_WRITE_REG, 5'h06, 8'h55});
    check(rx, {HI, 8'h11});
    send('{CMD_STORE_ONE, 5'h05, 8'h00});
    check(rx, {HI, 8'h55});
    wait_idle();
    send('{CMD_WRITE_REG, 5'h05, 8'h22});
    check(rx, ANG);
    @(posedge sys_clk);
    #1;
    rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    wait_idle();
    check({8'h00, config_bits[47:40]}, 16'h0011);
    check({8'h00, config_bits[55:48]}, {8'h00, FACTORY_R06});
    check({8'h00, config_bits[7:0]}, 16'h003c);
    conclude();
  end
endmodule : spi_cmd_nvm_control_tb
